//--- rtl/wdsup_pkg.sv
// Shared constants and types of the watchdog supervisor.
// Assumes a single 100 MHz clock; all times become cycle counts here.
package wdsup_pkg;

  // ==========================================================
  // Clock
  localparam int unsigned WDSUP_CLK_NS = 10;

  // ==========================================================
  // Timeout periods, in microseconds
  localparam int unsigned WDSUP_TOUT_A_US = 3400;
  localparam int unsigned WDSUP_TOUT_B_US = 6300;
  localparam int unsigned WDSUP_TOUT_C_US = 102000;
  localparam int unsigned WDSUP_TOUT_D_US = 1600000;

  // Alarm pulse width of the dual-edge variants, in microseconds
  localparam int unsigned WDSUP_ALARM_PW_US = 100000;
  // Least alarm pulse width, in microseconds
  localparam int unsigned WDSUP_ALARM_MIN_US = 10;
  // Least pulse that must be seen, and longest glitch to reject, in ns
  localparam int unsigned WDSUP_PULSE_MIN_NS = 1000;
  localparam int unsigned WDSUP_GLITCH_NS = 100;

  // ==========================================================
  // Derived cycle counts
  localparam int unsigned WDSUP_ALARM_PW_CYC =
    WDSUP_ALARM_PW_US * 1000 / WDSUP_CLK_NS;
  localparam int unsigned WDSUP_ALARM_MIN_CYC =
    (WDSUP_ALARM_MIN_US * 1000 + WDSUP_CLK_NS - 1) / WDSUP_CLK_NS;
  localparam int unsigned WDSUP_PULSE_MIN_CYC =
    WDSUP_PULSE_MIN_NS / WDSUP_CLK_NS;
  localparam int unsigned WDSUP_FILT_CYC =
    WDSUP_GLITCH_NS / WDSUP_CLK_NS + 1;

  // ==========================================================
  // Reset values
  localparam logic WDSUP_ALARM_N_RST = 1'h1;
  localparam logic WDSUP_PIN_RST = 1'h0;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    WDSUP_TOUT_A = 2'h0,
    WDSUP_TOUT_B = 2'h1,
    WDSUP_TOUT_C = 2'h2,
    WDSUP_TOUT_D = 2'h3
  } wdsup_tsel_t;

  typedef enum logic [1:0] {
    WDSUP_ST_COUNT = 2'h0,
    WDSUP_ST_ALARM = 2'h1,
    WDSUP_ST_INHIB = 2'h2
  } wdsup_state_t;

  typedef struct packed {
    logic inhibit;
    logic kick;
  } wdsup_pins_t;

  // Timeout in cycles for a period selection
  function automatic int unsigned wdsup_tout_cyc(wdsup_tsel_t sel);
    int unsigned us;
    case (sel)
      WDSUP_TOUT_A: us = WDSUP_TOUT_A_US;
      WDSUP_TOUT_B: us = WDSUP_TOUT_B_US;
      WDSUP_TOUT_C: us = WDSUP_TOUT_C_US;
      default: us = WDSUP_TOUT_D_US;
    endcase
    return us * 1000 / WDSUP_CLK_NS;
  endfunction

endpackage

//--- rtl/wdsup_deglitch.sv
// Two-flop synchroniser and glitch filter for the supervisor pins.
// Assumes asynchronous pin levels; output changes only after a stable run.
`timescale 1ns/10ps
`default_nettype none
module wdsup_deglitch #(
  parameter int unsigned STABLE_CYC = wdsup_pkg::WDSUP_FILT_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire wdsup_pkg::wdsup_pins_t pin_in,
  output var wdsup_pkg::wdsup_pins_t pin_out
);
  import wdsup_pkg::*;

  localparam int unsigned W = $bits(wdsup_pins_t);
  localparam int unsigned FW = $clog2(STABLE_CYC + 1);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] filt_r;
  logic [FW-1:0] stab_r [W];

  if (STABLE_CYC < 2 || STABLE_CYC + 2 >= WDSUP_PULSE_MIN_CYC)
  begin : g_bad
    $error("wdsup_deglitch: STABLE_CYC out of range");
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Per-pin synchroniser and filter
  for (genvar g = 0; g < W; g++)
  begin : g_pin
    always_ff @(posedge clock or negedge rst_n)
    begin
      if (!rst_n)
      begin
        meta_r[g] <= WDSUP_PIN_RST;
        sync_r[g] <= WDSUP_PIN_RST;
      end
      else
      begin
        meta_r[g] <= pin_in[g];
        sync_r[g] <= meta_r[g];
      end
    end

    // A level is taken only after STABLE_CYC equal samples
    always_ff @(posedge clock or negedge rst_n)
    begin
      if (!rst_n)
      begin
        stab_r[g] <= '0;
        filt_r[g] <= WDSUP_PIN_RST;
      end
      else if (sync_r[g] == filt_r[g])
      begin
        stab_r[g] <= '0;
      end
      else if (stab_r[g] == FW'(STABLE_CYC - 1))
      begin
        stab_r[g] <= '0;
        filt_r[g] <= sync_r[g];
      end
      else
      begin
        stab_r[g] <= stab_r[g] + FW'(1);
      end
    end

    a_filter_stable_run: assert property (
      $changed(filt_r[g]) |->
        $past(stab_r[g]) == FW'(STABLE_CYC - 1) &&
        $past(sync_r[g]) == filt_r[g])
      else $error("filtered pin changed without a stable run");
  end

  assign pin_out = filt_r;

endmodule
`default_nettype wire

//--- rtl/wdsup_top.sv
// Watchdog supervisor: kick input, inhibit input, active-low alarm pin.
// Assumes one 100 MHz clock; rst_n release marks the power start point.
`timescale 1ns/10ps
`default_nettype none

module wdsup_top #(
  parameter wdsup_pkg::wdsup_tsel_t TOUT_SEL = wdsup_pkg::WDSUP_TOUT_A,
  parameter int unsigned TIMEOUT_CYC = wdsup_pkg::wdsup_tout_cyc(TOUT_SEL),
  parameter int unsigned ALARM_PW_CYC = wdsup_pkg::WDSUP_ALARM_PW_CYC,
  parameter bit DUAL_EDGE = 1'b0,
  parameter bit OPEN_DRAIN = 1'b1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic watchdog_kick_in,
  input wire logic inhibit_in,
  output logic watchdog_alarm_n,
  output logic watchdog_alarm_oe
);
  import wdsup_pkg::*;

  localparam int unsigned MAX_CYC =
    (TIMEOUT_CYC > ALARM_PW_CYC) ? TIMEOUT_CYC : ALARM_PW_CYC;
  localparam int unsigned CNT_W = $clog2(MAX_CYC + 1) + 1;
  localparam logic [CNT_W-1:0] TOUT_LAST = CNT_W'(TIMEOUT_CYC - 1);
  localparam logic [CNT_W-1:0] PW_LAST = CNT_W'(ALARM_PW_CYC - 1);
  localparam logic [CNT_W-1:0] MIN_LAST = CNT_W'(WDSUP_ALARM_MIN_CYC - 1);

  // ==========================================================
  // Elaboration checks
  if (TIMEOUT_CYC <= WDSUP_ALARM_MIN_CYC)
  begin : g_bad_tout
    $error("wdsup_top: TIMEOUT_CYC too short");
  end
  if (DUAL_EDGE && ALARM_PW_CYC <= WDSUP_ALARM_MIN_CYC)
  begin : g_bad_pw
    $error("wdsup_top: ALARM_PW_CYC too short");
  end
  if (!DUAL_EDGE && TOUT_SEL != WDSUP_TOUT_A)
  begin : g_bad_variant
    $error("wdsup_top: single-edge build needs the shortest period");
  end

  // ==========================================================
  // Signals
  wdsup_pins_t pins_raw;
  wdsup_pins_t pins_f;
  wdsup_state_t state_r;
  wdsup_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic kick_prev_r;
  logic kick_rise;
  logic kick_fall;
  logic kick_clr;
  logic inhibit;
  logic alarm_n_r;
  logic alarm_oe_r;
  logic [CNT_W-1:0] low_len_r;

  // ==========================================================
  // Pin conditioning
  assign pins_raw.kick = watchdog_kick_in;
  assign pins_raw.inhibit = inhibit_in;

  // Pins reset to low, so a floating inhibit starts as enabled
  wdsup_deglitch #(
    .STABLE_CYC(WDSUP_FILT_CYC)
  ) u_deglitch (
    .clock(clock),
    .rst_n(rst_n),
    .pin_in(pins_raw),
    .pin_out(pins_f)
  );

  assign inhibit = pins_f.inhibit;

  // ==========================================================
  // Decodes
  function automatic logic is_alarm(input wdsup_state_t st);
    return st == WDSUP_ST_ALARM;
  endfunction

  // ==========================================================
  // Kick edge detection
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      kick_prev_r <= WDSUP_PIN_RST;
    end
    else
    begin
      kick_prev_r <= pins_f.kick;
    end
  end

  assign kick_rise = pins_f.kick & ~kick_prev_r;
  assign kick_fall = ~pins_f.kick & kick_prev_r;
  assign kick_clr = kick_rise | (DUAL_EDGE & kick_fall);

  // ==========================================================
  // State machine
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      WDSUP_ST_COUNT:
      begin
        if (inhibit)
        begin
          state_nxt = WDSUP_ST_INHIB;
        end
        else if (cnt_r == TOUT_LAST && !kick_clr)
        begin
          state_nxt = WDSUP_ST_ALARM;
        end
      end
      WDSUP_ST_ALARM:
      begin
        if (inhibit)
        begin
          if (cnt_r >= MIN_LAST)
          begin
            state_nxt = WDSUP_ST_INHIB;
          end
        end
        else if (DUAL_EDGE)
        begin
          if (cnt_r == PW_LAST)
          begin
            state_nxt = WDSUP_ST_COUNT;
          end
        end
        else if (cnt_r == TOUT_LAST ||
                 (kick_rise && cnt_r >= MIN_LAST))
        begin
          state_nxt = WDSUP_ST_COUNT;
        end
      end
      WDSUP_ST_INHIB:
      begin
        if (!inhibit)
        begin
          state_nxt = WDSUP_ST_COUNT;
        end
      end
      default:
      begin
        state_nxt = WDSUP_ST_COUNT;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= WDSUP_ST_COUNT;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Timeout and pulse counter
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
    end
    else if (state_nxt != state_r)
    begin
      cnt_r <= '0;
    end
    else if (state_r == WDSUP_ST_INHIB)
    begin
      cnt_r <= '0;
    end
    else if (state_r == WDSUP_ST_COUNT && kick_clr)
    begin
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // ==========================================================
  // Alarm pin drive
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alarm_n_r <= WDSUP_ALARM_N_RST;
      alarm_oe_r <= !OPEN_DRAIN;
    end
    else
    begin
      alarm_n_r <= !is_alarm(state_nxt);
      alarm_oe_r <= OPEN_DRAIN ? is_alarm(state_nxt) : 1'h1;
    end
  end

  assign watchdog_alarm_n = alarm_n_r;
  assign watchdog_alarm_oe = alarm_oe_r;

  // ==========================================================
  // Checks
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_len_r <= '0;
    end
    else if (!alarm_n_r)
    begin
      low_len_r <= low_len_r + CNT_W'(1);
    end
    else
    begin
      low_len_r <= '0;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_timeout_alarm: assert property (
    state_r == WDSUP_ST_COUNT && cnt_r == TOUT_LAST &&
      !inhibit && !kick_clr |=> !alarm_n_r ##1 cnt_r == CNT_W'(1))
    else $error("timeout did not raise the alarm");

  a_edge_clears: assert property (
    $changed(alarm_n_r) |-> cnt_r == '0)
    else $error("alarm transition left the counter running");

  a_inhibit_clears: assert property (
    inhibit && state_r == WDSUP_ST_COUNT |=> cnt_r == '0 && alarm_n_r)
    else $error("inhibit did not clear the counter");

  a_kick_clears: assert property (
    state_r == WDSUP_ST_COUNT && !inhibit && kick_clr &&
      cnt_r != '0 |=> cnt_r == '0 && alarm_n_r)
    else $error("kick edge did not clear the counter");

  a_dual_hold: assert property (
    DUAL_EDGE && state_r == WDSUP_ST_ALARM && !inhibit &&
      cnt_r < PW_LAST |=> !alarm_n_r)
    else $error("dual-edge alarm ended before its width");

  a_single_release: assert property (
    !DUAL_EDGE && state_r == WDSUP_ST_ALARM && !inhibit &&
      kick_rise && cnt_r >= MIN_LAST |=> alarm_n_r)
    else $error("kick after least width did not end alarm");

  a_alarm_min_width: assert property (
    $rose(alarm_n_r) |-> low_len_r >= CNT_W'(WDSUP_ALARM_MIN_CYC))
    else $error("alarm pulse shorter than its least width");

  a_alarm_max_width: assert property (
    $rose(alarm_n_r) |->
      low_len_r == (DUAL_EDGE ? CNT_W'(ALARM_PW_CYC) :
                    CNT_W'(TIMEOUT_CYC)) || $past(inhibit) ||
      (!DUAL_EDGE && low_len_r < CNT_W'(TIMEOUT_CYC)))
    else $error("alarm pulse width wrong");

  a_inhibit_high: assert property (
    state_r == WDSUP_ST_INHIB |-> alarm_n_r && cnt_r == '0)
    else $error("alarm low while inhibited");

  a_drive_mode: assert property (
    alarm_oe_r == (OPEN_DRAIN ? !alarm_n_r : 1'h1))
    else $error("alarm pin drive mode wrong");

  a_dual_kick_ignored: assert property (
    DUAL_EDGE && state_r == WDSUP_ST_ALARM && !inhibit && kick_clr &&
      cnt_r < PW_LAST |=> !alarm_n_r && cnt_r != '0)
    else $error("dual-edge alarm reacted to a kick");

  a_count_bound: assert property (
    state_r == WDSUP_ST_COUNT |-> cnt_r <= TOUT_LAST)
    else $error("timeout counter ran past its period");

  a_count_step: assert property (
    state_r == WDSUP_ST_COUNT && !inhibit && !kick_clr &&
      cnt_r != TOUT_LAST |=> cnt_r == $past(cnt_r) + CNT_W'(1))
    else $error("timeout counter did not advance");

  a_inhibit_hold: assert property (
    state_r == WDSUP_ST_ALARM && inhibit &&
      cnt_r < MIN_LAST |=> !alarm_n_r)
    else $error("inhibit cut the alarm below its least width");

  a_inhibit_release: assert property (
    state_r == WDSUP_ST_ALARM && inhibit && cnt_r >= MIN_LAST |=>
      alarm_n_r && state_r == WDSUP_ST_INHIB)
    else $error("inhibit did not release the alarm");

  a_inhibit_exit: assert property (
    state_r == WDSUP_ST_INHIB && !inhibit |=>
      state_r == WDSUP_ST_COUNT && cnt_r == '0)
    else $error("counting did not restart after inhibit");

  a_single_timeout_end: assert property (
    !DUAL_EDGE && state_r == WDSUP_ST_ALARM &&
      cnt_r == TOUT_LAST |=> alarm_n_r)
    else $error("single-edge alarm outlasted one timeout");

  a_single_early_kick: assert property (
    !DUAL_EDGE && state_r == WDSUP_ST_ALARM && !inhibit && kick_rise &&
      cnt_r < MIN_LAST |=> !alarm_n_r)
    else $error("early kick cut the alarm short");

  a_alarm_count_match: assert property (
    state_r == WDSUP_ST_ALARM |-> cnt_r == low_len_r)
    else $error("alarm counter lost track of the low time");

  c_timeout: cover property (
    state_r == WDSUP_ST_COUNT ##1 state_r == WDSUP_ST_ALARM);
  c_kick_clear: cover property (
    state_r == WDSUP_ST_COUNT && kick_clr && cnt_r > CNT_W'(1));
  c_inhibit_in_alarm: cover property (
    state_r == WDSUP_ST_ALARM ##1 state_r == WDSUP_ST_INHIB);
  c_alarm_end: cover property ($rose(alarm_n_r));
  c_dual_end: cover property (
    DUAL_EDGE && state_r == WDSUP_ST_ALARM && cnt_r == PW_LAST);

endmodule
`default_nettype wire

//--- verif/wdsup_host.sv
// Host model for the watchdog supervisor: drives the kick pin.
// Assumes a free-running clock; the pin changes on falling edges.
`timescale 1ns/10ps
`default_nettype none
module wdsup_host (
  input wire logic clock,
  input wire logic run,
  input wire logic lvl,
  input var int gap,
  input var int wide,
  output var logic kick
);
  int cnt = 0;
  // ==========================================================
  // Periodic kick while running, a held level otherwise
  always @(negedge clock)
  begin
    cnt <= (run && cnt < gap - 1) ? cnt + 1 : 0;
    kick <= run ? (cnt < wide) : lvl;
  end
endmodule
`default_nettype wire

//--- verif/wdsup_top_test.sv
// Self-checking bench: single-edge and dual-edge supervisors side by side.
// Assumes shortened timeout and alarm width; inputs change on falling edges.
`timescale 1ns/10ps
`default_nettype none
module wdsup_top_test;
  import wdsup_pkg::*;
  localparam int TO = 3000;
  localparam int PW = 2000;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic inhibit_in = 1'h0;
  logic run = 1'h0;
  logic lvl = 1'h0;
  int gap = 1000;
  int wide = 100;
  logic kick;
  logic s_n;
  logic s_oe;
  logic d_n;
  logic d_oe;
  int n_fail = 0;
  int tests_run = 0;
  int n;
  int m;

  // ==========================================================
  // Clock, host and the two builds
  always #5 clock = ~clock;
  wdsup_host u_wdsup_host (.clock(clock), .run(run), .lvl(lvl), .gap(gap),
    .wide(wide), .kick(kick));
  wdsup_top #(.TIMEOUT_CYC(TO), .ALARM_PW_CYC(PW), .DUAL_EDGE(1'b0))
  u_wdsup_top (.clock(clock), .rst_n(rst_n), .watchdog_kick_in(kick),
    .inhibit_in(inhibit_in), .watchdog_alarm_n(s_n), .watchdog_alarm_oe(s_oe));
  wdsup_top #(.TIMEOUT_CYC(TO), .ALARM_PW_CYC(PW), .DUAL_EDGE(1'b1),
    .OPEN_DRAIN(1'b0))
  u_wdsup_top_dual (.clock(clock), .rst_n(rst_n), .watchdog_kick_in(kick),
    .inhibit_in(inhibit_in), .watchdog_alarm_n(d_n), .watchdog_alarm_oe(d_oe));

  // ==========================================================
  // Helpers and compares
  task automatic close_out;
    if (n_fail == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check_bit(input logic got, input logic exp, input string w);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: %s is %b", $time, w, got);
    end
  endtask

  task automatic check_rng(input int got, input int lo, input int hi,
    input string w);
    tests_run++;
    if (got < lo || got > hi)
    begin
      n_fail++;
      $display("Error at %0t: %s count %0d", $time, w, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask

  task automatic meas(input bit dual, input logic lv, output int k);
    k = 0;
    while ((dual ? d_n : s_n) === lv && k < 20000)
    begin
      @(negedge clock);
      k++;
    end
    if (k >= 20000)
    begin
      n_fail++;
      $display("Error at %0t: alarm level stuck", $time);
    end
  endtask

  task automatic do_reset;
    rst_n = 1'h0;
    run = 1'h0;
    lvl = 1'h0;
    inhibit_in = 1'h0;
    cyc(4);
    rst_n = 1'h1;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_start;
    do_reset();
    meas(0, 1'h1, n);
    check_rng(n, TO - 2, TO + 2, "startup high");
    check_bit(d_n, 1'h0, "dual alarm");
    check_bit(s_oe, 1'h1, "drive low");
    check_bit(d_oe, 1'h1, "push-pull low");
    meas(1, 1'h0, n);
    check_rng(n, PW - 2, PW + 2, "dual low");
    meas(0, 1'h0, m);
    check_rng(n + m, TO - 3, TO + 3, "single low");
    check_bit(s_oe, 1'h0, "released");
    check_bit(d_oe, 1'h1, "push-pull high");
    meas(0, 1'h1, n);
    check_rng(n, TO - 2, TO + 2, "toggle high");
  endtask

  task automatic t_kick;
    do_reset();
    gap = 1000;
    wide = 100;
    run = 1'h1;
    m = 0;
    repeat (10000)
    begin
      @(negedge clock);
      if (s_n !== 1'h1 || d_n !== 1'h1)
        m++;
    end
    check_rng(m, 0, 0, "kicked alarm");
    run = 1'h0;
    meas(0, 1'h1, n);
    check_rng(n, TO - 1020, TO + 20, "stopped kick");
  endtask

  task automatic t_glitch;
    do_reset();
    gap = 500;
    wide = 5;
    run = 1'h1;
    meas(0, 1'h1, n);
    check_rng(n, TO - 2, TO + 2, "glitch kick");
    run = 1'h0;
  endtask

  task automatic t_edges;
    do_reset();
    cyc(500);
    lvl = 1'h1;
    cyc(2000);
    lvl = 1'h0;
    cyc(1200);
    check_bit(s_n, 1'h0, "single rise only");
    check_bit(d_n, 1'h1, "dual fall clear");
    cyc(1900);
    lvl = 1'h1;
    cyc(1800);
    check_bit(d_n, 1'h0, "dual kick ignored");
  endtask

  task automatic t_release;
    do_reset();
    meas(0, 1'h1, n);
    cyc(500);
    lvl = 1'h1;
    cyc(100);
    check_bit(s_n, 1'h0, "early kick ignored");
    lvl = 1'h0;
    cyc(600);
    lvl = 1'h1;
    meas(0, 1'h0, n);
    check_rng(n, 10, 30, "kick ends alarm");
  endtask

  task automatic t_inhibit;
    do_reset();
    cyc(100);
    inhibit_in = 1'h1;
    cyc(5000);
    check_bit(s_n, 1'h1, "inhibited");
    inhibit_in = 1'h0;
    meas(0, 1'h1, n);
    check_rng(n, TO, TO + 20, "after inhibit");
    cyc(10);
    inhibit_in = 1'h1;
    meas(0, 1'h0, n);
    check_rng(n + 10, 990, 1030, "least alarm");
    cyc(100);
    check_bit(d_n, 1'h1, "dual inhibited");
    inhibit_in = 1'h0;
    cyc(1500);
    inhibit_in = 1'h1;
    cyc(5);
    inhibit_in = 1'h0;
    meas(0, 1'h1, n);
    check_rng(n, 1500, 1520, "inhibit glitch");
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    t_start();
    t_kick();
    t_glitch();
    t_edges();
    t_release();
    t_inhibit();
    close_out();
  end

  initial
  begin
    #1000000;
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire
